// *** design/wwd_map.svh ***
// Register map, field positions, reset values and timing counts of the windowed watchdog.
// Assumes inclusion by bare name from the package and the top module.
`ifndef WWD_MAP_SVH
`define WWD_MAP_SVH

// Byte offsets of the APB registers.
`define WWD_OFS_CLEAR      12'h000
`define WWD_OFS_MODE       12'h004
`define WWD_OFS_CAUSE      12'h008
`define WWD_OFS_STATUS     12'h00c

// Clear register keys.
`define WWD_KEY_ARM        8'h5a
`define WWD_KEY_FIRE       8'ha5

// Mode register fields and reset values.
`define WWD_MODE_PER_LSB   0
`define WWD_MODE_WIN_LSB   4
`define WWD_PER_RST        3'h7
`define WWD_WIN_RST        2'h0
`define WWD_PER_NOWIN_MAX  3'h3

// Reset cause register bits.
`define WWD_CAUSE_OVF_BIT  0
`define WWD_CAUSE_INV_BIT  1

// Status register fields.
`define WWD_STAT_PTR_BIT   16
`define WWD_STAT_WARN_BIT  17

// CPU level at which clearing is blocked.
`define WWD_LEVEL_HANDLER  2'h2

// Timing: bus clock and watchdog clock in Hz, tick divider derived from both.
`define WWD_PCLK_HZ        25000000
`define WWD_WDCLK_HZ       1024
`define WWD_TICK_DIV       (`WWD_PCLK_HZ / `WWD_WDCLK_HZ)

`endif

// *** design/wwd_pkg.sv ***
// Types shared by the windowed watchdog modules.
// Assumes the map header is on the include path.
`include "wwd_map.svh"

package wwd_pkg;

    // Overflow tracking state, one-hot.
    typedef enum logic [1:0] {
        WWD_ST_RUN    = 2'b01,
        WWD_ST_WARNED = 2'b10
    } wwd_state_t;

    // Window mode select codes; the fourth code behaves as window off.
    typedef enum logic [1:0] {
        WWD_WIN_OFF = 2'h0,
        WWD_WIN_75  = 2'h1,
        WWD_WIN_50  = 2'h2,
        WWD_WIN_RSV = 2'h3
    } wwd_win_t;

    // Log2 of the overflow period in watchdog ticks per period code.
    // 7.8, 15.6, 31.3, 62.5, 125, 500, 2000, 8000 ms at 1024 ticks per second.
    function automatic logic [3:0] wwd_period_shift(input logic [2:0] code);
        logic [3:0] sh;
        sh = 4'h3;
        case (code)
            3'h0:    sh = 4'h3;
            3'h1:    sh = 4'h4;
            3'h2:    sh = 4'h5;
            3'h3:    sh = 4'h6;
            3'h4:    sh = 4'h7;
            3'h5:    sh = 4'h9;
            3'h6:    sh = 4'hb;
            default: sh = 4'hd;
        endcase
        return sh;
    endfunction

endpackage

// *** design/wwd_tick_gen.sv ***
// Divider that turns the bus clock into one-cycle watchdog ticks.
// Assumes pclk is free running; halt freezes the divider between ticks.
module wwd_tick_gen #(
    parameter int DIV = 24414
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic halt,
    output logic      tick
);

    logic [31:0] div_r;   // Cycles seen in the current tick period.
    logic        last;    // Final cycle of the period.

    assign last = (div_r == 32'(DIV - 1));

    // -----------------------------------------------------------
    // Divider
    // -----------------------------------------------------------
    // The divider stops in halt so a stop mode does not leak a partial period.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 32'h0;
            tick  <= 1'b0;
        end else begin
            tick  <= last && !halt;
            if (!halt) begin
                div_r <= last ? 32'h0 : div_r + 32'h1;
            end
        end
    end

endmodule // wwd_tick_gen

// *** design/wwd_top.sv ***
// Windowed watchdog with an APB register file.
// Assumes an APB master on pclk and a reset controller that acts on wdt_reset_req.
//
// Summary of operation
// - Window mode: overflow raises reset, no interrupt.
// - Window mode: clear in closed window resets.
// - Overflow reset sets its cause flag, resets.
// - Invalid clear sets its own flag, resets.
// - Window mode one allows last 75 percent.
// - Window mode two allows last 50 percent.
// - Periods up to 62.5 ms disable window.
// - Eight period codes from 7.8 to 8000 ms.
// - Periods come from a 1.024 kHz tick.
// - Then a5 with pointer one restarts counter.
// - Counter runs from reset release.
// - Overflow forces the sequence pointer to zero.
// - No clearing at CPU interrupt level two.
// - Pointer toggles per clear write, zeroed on overflow.
// - Window off: interrupt first, reset on second.
// - Counter halts in stop modes.
`include "wwd_map.svh"
module wwd_top
    import wwd_pkg::*;
#(
    parameter int TICK_DIV = `WWD_TICK_DIV,
    parameter int CNT_W    = 14
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [1:0]  cpu_interrupt_level,
    input  wire logic        stop_mode,
    output logic             wdt_irq,
    output logic             wdt_reset_req
);

    // -----------------------------------------------------------
    // Declarations
    // -----------------------------------------------------------
    logic [CNT_W-1:0] cnt_r;                       // Watchdog counter.
    logic [CNT_W-1:0] cnt_nxt;                     // Next counter value.
    logic             clear_sequence_pointer_r;    // Toggles on each clear write unless an overflow zeroes it.
    logic             armed_r;                     // Last clear write was an accepted 5a.
    logic [2:0]       period_sel_r;                // Overflow period code.
    logic [1:0]       window_sel_r;                // Window mode select.
    logic             overflow_reset_flag_r;       // Sticky overflow cause.
    logic             invalid_clear_reset_flag_r;  // Sticky invalid clear cause.
    wwd_state_t       state_r;                     // Overflow tracking state.
    wwd_state_t       state_nxt;                   // Next tracking state.
    logic             tick;                        // One watchdog clock period elapsed.
    logic             tick_en;                     // Tick while not stopped.
    logic [3:0]       per_sh;                      // Log2 of period in ticks.
    logic [CNT_W-1:0] lim;                         // Last count before overflow.
    logic             ovf;                         // Counter overflows this cycle.
    logic             win_on;                      // Window behaviour active.
    logic             forbid;                      // Count lies in the closed window.
    logic             acc;                         // APB access phase, answer pending.
    logic             done;                        // APB access completes this edge.
    logic             wr_fire;                     // Write takes effect this edge.
    logic             mapped;                      // Address hits a register.
    logic             sel_clear;                   // Address decodes.
    logic             sel_mode;
    logic             sel_cause;
    logic             sel_status;
    logic             clr_wr;                      // Write to the clear register.
    logic             key_arm;                     // Clear data is the arm key.
    logic             key_fire;                    // Clear data is the fire key.
    logic             seq_done;                    // Complete two-write sequence.
    logic             level_ok;                    // CPU level allows clearing.
    logic             restart_ok;                  // Valid restart request.
    logic             inv_clr;                     // Restart lands in closed window.
    logic             fire_ovf;                    // Overflow that raises reset.
    logic             warn_ovf;                    // Overflow that raises interrupt.
    logic             rst_evt;                     // Any watchdog reset event.
    logic [31:0]      rd_mux;                      // Read data selection.

    // -----------------------------------------------------------
    // Watchdog clock
    // -----------------------------------------------------------
    // The tick and the count stop together in a stop mode.
    wwd_tick_gen #(
        .DIV     (TICK_DIV)
    ) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .halt    (stop_mode),
        .tick    (tick)
    );

    assign tick_en = tick && !stop_mode;

    // -----------------------------------------------------------
    // Period and window decode
    // -----------------------------------------------------------
    assign per_sh = wwd_period_shift(period_sel_r);
    assign lim    = {CNT_W{1'b1}} >> (CNT_W - int'(per_sh));
    assign ovf    = tick_en && (cnt_r == lim);

    // Short periods never use the window, whatever the select holds.
    assign win_on = (period_sel_r > `WWD_PER_NOWIN_MAX) &&
                    ((window_sel_r == WWD_WIN_75) || (window_sel_r == WWD_WIN_50));

    // The closed window is the first quarter or first half of the period.
    assign forbid = (window_sel_r == WWD_WIN_75) ? (cnt_r <= (lim >> 2))
                                                 : (cnt_r <= (lim >> 1));

    // -----------------------------------------------------------
    // APB decode
    // -----------------------------------------------------------
    // One wait state: pready rises in the second access cycle.
    assign acc        = psel && penable && !pready;
    assign done       = psel && penable && pready;
    assign wr_fire    = done && pwrite;
    assign sel_clear  = (paddr == `WWD_OFS_CLEAR);
    assign sel_mode   = (paddr == `WWD_OFS_MODE);
    assign sel_cause  = (paddr == `WWD_OFS_CAUSE);
    assign sel_status = (paddr == `WWD_OFS_STATUS);
    assign mapped     = sel_clear || sel_mode || sel_cause || sel_status;

    // The clear register reads as zero; the keys are write only.
    assign rd_mux = sel_mode   ? {26'h0, window_sel_r, 1'b0, period_sel_r} :
                    sel_cause  ? {30'h0, invalid_clear_reset_flag_r,
                                  overflow_reset_flag_r} :
                    sel_status ? {14'h0, (state_r == WWD_ST_WARNED),
                                  clear_sequence_pointer_r,
                                  (16 - CNT_W)'(0), cnt_r} :
                    32'h0;

    // -----------------------------------------------------------
    // Clear sequence decode
    // -----------------------------------------------------------
    assign clr_wr     = wr_fire && sel_clear;
    assign key_arm    = (pwdata[7:0] == `WWD_KEY_ARM);
    assign key_fire   = (pwdata[7:0] == `WWD_KEY_FIRE);
    // Only a 5a accepted at pointer zero arms; a5 needs pointer one and arming.
    assign seq_done   = clr_wr && key_fire && clear_sequence_pointer_r && armed_r;
    assign level_ok   = (cpu_interrupt_level != `WWD_LEVEL_HANDLER);
    assign restart_ok = seq_done && level_ok;
    assign inv_clr    = restart_ok && win_on && forbid;
    assign fire_ovf   = ovf && (win_on || (state_r == WWD_ST_WARNED));
    assign warn_ovf   = ovf && !win_on && (state_r == WWD_ST_RUN);
    assign rst_evt    = fire_ovf || inv_clr;

    // -----------------------------------------------------------
    // Counter next value
    // -----------------------------------------------------------
    // Overflow, restart and reset events all start a fresh period.
    always_comb begin
        if (rst_evt || restart_ok || ovf) begin
            cnt_nxt = '0;
        end else if (tick_en) begin
            cnt_nxt = cnt_r + CNT_W'(1);
        end else begin
            cnt_nxt = cnt_r;
        end
    end

    // Tracking state: a first overflow without window warns, a clear forgives.
    always_comb begin
        case (state_r)
            WWD_ST_RUN: begin
                state_nxt = warn_ovf ? WWD_ST_WARNED : WWD_ST_RUN;
            end
            WWD_ST_WARNED: begin
                state_nxt = (rst_evt || restart_ok) ? WWD_ST_RUN : WWD_ST_WARNED;
            end
            default: begin
                state_nxt = WWD_ST_RUN;
            end
        endcase
    end

    // -----------------------------------------------------------
    // Counter, pointer and state
    // -----------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r   <= '0;
            state_r <= WWD_ST_RUN;
        end else begin
            cnt_r   <= cnt_nxt;
            state_r <= state_nxt;
        end
    end

    // Overflow beats a clear write landing in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clear_sequence_pointer_r <= 1'b0;
            armed_r                  <= 1'b0;
        end else if (ovf) begin
            clear_sequence_pointer_r <= 1'b0;
            armed_r                  <= 1'b0;
        end else if (clr_wr) begin
            clear_sequence_pointer_r <= !clear_sequence_pointer_r;
            armed_r                  <= key_arm && !clear_sequence_pointer_r;
        end
    end

    // -----------------------------------------------------------
    // Mode and cause registers
    // -----------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_sel_r <= `WWD_PER_RST;
            window_sel_r <= `WWD_WIN_RST;
        end else if (wr_fire && sel_mode) begin
            period_sel_r <= pwdata[`WWD_MODE_PER_LSB +: 3];
            window_sel_r <= pwdata[`WWD_MODE_WIN_LSB +: 2];
        end
    end

    // Write one clears a flag; a cause arriving in the same cycle wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_reset_flag_r      <= 1'b0;
            invalid_clear_reset_flag_r <= 1'b0;
        end else begin
            if (fire_ovf) begin
                overflow_reset_flag_r <= 1'b1;
            end else if (wr_fire && sel_cause && pwdata[`WWD_CAUSE_OVF_BIT]) begin
                overflow_reset_flag_r <= 1'b0;
            end
            if (inv_clr) begin
                invalid_clear_reset_flag_r <= 1'b1;
            end else if (wr_fire && sel_cause && pwdata[`WWD_CAUSE_INV_BIT]) begin
                invalid_clear_reset_flag_r <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------
    // Reset request and interrupt are one-cycle pulses.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_reset_req <= 1'b0;
            wdt_irq       <= 1'b0;
        end else begin
            wdt_reset_req <= rst_evt;
            wdt_irq       <= warn_ovf;
        end
    end

    // Read data and error are captured on the same edge that raises pready.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= acc;
            pslverr <= acc && !mapped;
            prdata  <= (acc && !pwrite) ? rd_mux : 32'h0;
        end
    end

    // -----------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // A reset pulse lasts exactly one cycle.
    sequence s_reset_pulse;
        wdt_reset_req ##1 !wdt_reset_req;
    endsequence

    a_win_ovf_reset: assert property (ovf && win_on |=> s_reset_pulse and !wdt_irq)
        else $error("window overflow did not give a lone reset pulse");
    a_ovf_flag_set: assert property (fire_ovf |=> overflow_reset_flag_r && wdt_reset_req)
        else $error("overflow reset without its cause flag");
    a_inv_clear_reset: assert property (
        restart_ok && win_on && forbid |=> invalid_clear_reset_flag_r ##0 s_reset_pulse)
        else $error("clear in closed window did not reset");
    a_open_clear_ok: assert property (
        restart_ok && !forbid && !ovf |=> cnt_r == '0 && !wdt_reset_req)
        else $error("valid clear did not restart quietly");
    a_short_no_win: assert property (period_sel_r <= `WWD_PER_NOWIN_MAX |-> !win_on)
        else $error("window active on a short period");
    a_ptr_toggle: assert property (
        clr_wr && !ovf |=> clear_sequence_pointer_r != $past(clear_sequence_pointer_r))
        else $error("pointer did not toggle on clear write");
    a_ovf_ptr_zero: assert property (ovf |=> !clear_sequence_pointer_r && !armed_r)
        else $error("pointer not zeroed on overflow");
    a_level_block: assert property (
        clr_wr && !level_ok && !tick_en |=> cnt_r == $past(cnt_r) && !wdt_reset_req)
        else $error("clear took effect at handler level");
    a_lone_fire: assert property (
        clr_wr && key_fire && !clear_sequence_pointer_r && !tick_en
        |=> cnt_r == $past(cnt_r) && clear_sequence_pointer_r)
        else $error("a5 at pointer zero restarted the counter");
    a_stop_halt: assert property (stop_mode && !restart_ok |=> $stable(cnt_r))
        else $error("counter moved in stop mode");
    // The state is checked at once, since a handler may clear right after the interrupt.
    a_nowin_warn: assert property (
        warn_ovf |=> wdt_irq && !wdt_reset_req && state_r == WWD_ST_WARNED)
        else $error("first overflow without window did not warn");

endmodule // wwd_top

// *** dv/wwd_sys_ctrl.sv ***
// Model of the system reset controller and the watchdog interrupt handler.
// Assumes both request lines are one-cycle pulses on pclk.
module wwd_sys_ctrl (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic wdt_irq,
    input  wire logic wdt_reset_req,
    output int        irq_cnt,
    output int        rst_cnt,
    output int        irq_cyc,
    output int        rst_cyc
);
    timeunit 1ns;
    timeprecision 1ns;
    int cyc; // Free running cycle stamp.
    // The handler is always present, so every interrupt is taken and counted.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc     <= 0;
            irq_cnt <= 0;
            rst_cnt <= 0;
            irq_cyc <= 0;
            rst_cyc <= 0;
        end else begin
            cyc <= cyc + 1;
            if (wdt_irq) begin
                irq_cnt <= irq_cnt + 1;
                irq_cyc <= cyc;
            end
            // A reset request is logged; the block itself keeps running here.
            if (wdt_reset_req) begin
                rst_cnt <= rst_cnt + 1;
                rst_cyc <= cyc;
            end
        end
    end
endmodule // wwd_sys_ctrl

// *** dv/windowed_watchdog_bench.sv ***
// Self-checking bench for the windowed watchdog, driven over APB.
// Assumes the tick divider is shortened to TD bus cycles per tick.
`include "wwd_map.svh"
module windowed_watchdog_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TD = 4; // Short tick keeps the run brief.
    logic        pclk, presetn, psel, penable, pwrite, stop_mode, pready, pslverr;
    logic        wdt_irq, wdt_reset_req;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat, d;
    logic [1:0]  cpu_interrupt_level;
    logic        rerr;
    int          irq_cnt, rst_cnt, irq_cyc, rst_cyc, num_errors, total_checks;
    int          cycles, c0, r0, i0, t, lim, seed;

    wwd_top #(.TICK_DIV(TD), .CNT_W(14)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cpu_interrupt_level(cpu_interrupt_level),
        .stop_mode(stop_mode), .wdt_irq(wdt_irq), .wdt_reset_req(wdt_reset_req));
    wwd_sys_ctrl sys (.pclk(pclk), .presetn(presetn), .wdt_irq(wdt_irq),
        .wdt_reset_req(wdt_reset_req), .irq_cnt(irq_cnt), .rst_cnt(rst_cnt),
        .irq_cyc(irq_cyc), .rst_cyc(rst_cyc));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Overflow period in ticks for a period code.
    function automatic int per_ticks(input int code);
        return 1 << ((code < 4) ? code + 3 : 2 * code - 1);
    endfunction
    // Ticks at the start of a period during which a clear is refused.
    function automatic int closed(input int code, input int win);
        if (code < 4 || win == 0 || win == 3) return 0;
        return per_ticks(code) >> ((win == 1) ? 2 : 1);
    endfunction
    // One APB transfer; holds the request until pready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // The whole clear sequence lives in this one place.
    task automatic clr();
        apb(1'b1, `WWD_OFS_CLEAR, 32'h5a);
        apb(1'b1, `WWD_OFS_CLEAR, 32'ha5);
    endtask
    // Polls the counter; a stuck counter is ended by the run timeout as a failure.
    task automatic wait_cnt(input int tg);
        do begin
            apb(1'b0, `WWD_OFS_STATUS, 32'h0);
        end while (rdat[13:0] < tg);
    endtask
    task automatic wait_rst(input int v);
        while (rst_cnt <= v) begin
            @(posedge pclk);
        end
    endtask
    task automatic give_verdict();
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            give_verdict();
        end
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        {psel, penable, pwrite, stop_mode, presetn} = 5'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        cpu_interrupt_level = 2'h0;
        seed = $urandom(2020);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `WWD_OFS_MODE, 32'h0);
        chk(rdat, 32'h7);
        apb(1'b0, 12'h010, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        chk(rdat, 32'h0);
        apb(1'b0, `WWD_OFS_STATUS, 32'h0);
        c0 = rdat[13:0];
        repeat (40) @(posedge pclk);
        apb(1'b0, `WWD_OFS_STATUS, 32'h0);
        chk(rdat[13:0] > c0, 1);
        for (int i = 0; i < 4; i++) begin
            d = $urandom;
            apb(1'b1, `WWD_OFS_MODE, d);
            apb(1'b0, `WWD_OFS_MODE, 32'h0);
            chk(rdat, d & 32'h37);
        end
        apb(1'b1, `WWD_OFS_MODE, 32'h7);
        $display("test reset done");
        // Level two blocks the restart; a lone a5 only toggles the pointer.
        wait_cnt(20);
        cpu_interrupt_level <= 2'h2;
        clr();
        apb(1'b0, `WWD_OFS_STATUS, 32'h0);
        chk(rdat[13:0] >= 20, 1);
        cpu_interrupt_level <= 2'h0;
        apb(1'b1, `WWD_OFS_CLEAR, 32'ha5);
        apb(1'b0, `WWD_OFS_STATUS, 32'h0);
        chk({rdat[16], rdat[13:0] >= 20}, 2'b11);
        apb(1'b1, `WWD_OFS_CLEAR, 32'ha5);
        apb(1'b0, `WWD_OFS_STATUS, 32'h0);
        chk(rdat[16], 1'b0);
        clr();
        apb(1'b0, `WWD_OFS_STATUS, 32'h0);
        chk(rdat[13:0] < 4, 1);
        stop_mode <= 1'b1;
        apb(1'b0, `WWD_OFS_STATUS, 32'h0);
        c0 = rdat[13:0];
        repeat (60) @(posedge pclk);
        apb(1'b0, `WWD_OFS_STATUS, 32'h0);
        chk(rdat[13:0], c0);
        stop_mode <= 1'b0;
        $display("test clear sequence done");
        // Short periods ignore the window bits; code 4 with the spare window code is off too.
        for (int code = 0; code < 5; code++) begin
            apb(1'b1, `WWD_OFS_MODE, ((code == 4) ? 32'h30 : 32'h10) | code);
            clr();
            r0 = rst_cnt;
            i0 = irq_cnt;
            wait_rst(r0);
            chk(irq_cnt - i0, 1);
            chk(rst_cyc - irq_cyc, per_ticks(code) * TD);
            apb(1'b0, `WWD_OFS_CAUSE, 32'h0);
            chk(rdat, 32'h1);
            apb(1'b1, `WWD_OFS_CAUSE, 32'h3);
        end
        $display("test short periods done");
        // Clears early and late in both window modes.
        for (int w = 1; w < 3; w++) begin
            for (int k = 0; k < 2; k++) begin
                lim = closed(4, w);
                t = k ? $urandom_range(118, lim + 6) : $urandom_range(lim - 8, 0);
                apb(1'b1, `WWD_OFS_MODE, 32'h4);
                clr();
                apb(1'b1, `WWD_OFS_MODE, (w << 4) | 4);
                wait_cnt(t);
                r0 = rst_cnt;
                clr();
                repeat (3) @(posedge pclk);
                chk(rst_cnt - r0, (t < lim) ? 1 : 0);
                apb(1'b0, `WWD_OFS_CAUSE, 32'h0);
                chk(rdat, (t < lim) ? 32'h2 : 32'h0);
                apb(1'b1, `WWD_OFS_CAUSE, 32'h3);
                apb(1'b0, `WWD_OFS_CAUSE, 32'h0);
                chk(rdat, 32'h0);
            end
        end
        $display("test window clears done");
        // Only a 5a write, no restart: overflow resets at once and clears the pointer.
        apb(1'b1, `WWD_OFS_MODE, 32'h4);
        clr();
        apb(1'b1, `WWD_OFS_MODE, 32'h24);
        wait_cnt(80);
        apb(1'b1, `WWD_OFS_CLEAR, 32'h5a);
        r0 = rst_cnt;
        i0 = irq_cnt;
        wait_rst(r0);
        chk(irq_cnt - i0, 0);
        apb(1'b0, `WWD_OFS_CAUSE, 32'h0);
        chk(rdat, 32'h1);
        apb(1'b0, `WWD_OFS_STATUS, 32'h0);
        chk(rdat[16], 1'b0);
        $display("test overflow done");
        give_verdict();
    end
endmodule // windowed_watchdog_bench
